/* File: hw/cocb_pkg.sv */
package cocb_pkg;
  // ==========================================
  // object indices
  localparam logic [15:0] IDX_DEVICE_TYPE = 16'h1000;
  localparam logic [15:0] IDX_ERROR_FLAGS = 16'h1001;
  localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
  localparam logic [15:0] IDX_SYNC_ID = 16'h1005;
  localparam logic [15:0] IDX_SYNC_PERIOD = 16'h1006;
  localparam logic [15:0] IDX_DEV_NAME = 16'h1008;
  localparam logic [15:0] IDX_HW_VERSION = 16'h1009;
  // ==========================================
  // field layouts and reset values
  localparam logic [15:0] PROFILE_NUM = 16'h0191;
  localparam logic [11:0] SIG_UPPER_ZERO = 12'h000;
  localparam int ERR_GENERIC_BIT = 0;
  localparam int ERR_COMM_BIT = 4;
  localparam int ERR_VENDOR_BIT = 7;
  localparam logic [7:0] ERR_FLAGS_RESET = 8'h00;
  localparam logic [31:0] DEVICE_TYPE_RESET = 32'h0000_0000;
  localparam logic [31:0] SYNC_ID_RESET = 32'h8000_0080;
  localparam int SYNC_PRODUCER_BIT = 30;
  localparam logic [31:0] SYNC_PERIOD_RESET = 32'h0000_0000;
  localparam int HIST_DEPTH = 10;
  // ==========================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int HALF_US_CYC = CLK_MHZ / 2;
  // watchdog is 1.5 periods, counted in half microseconds
  localparam int WD_HALF_US_PER_US = 3;
  localparam int SYNC_FAST_MS = 90;
  localparam logic [39:0] SYNC_FAST_US = 40'(SYNC_FAST_MS * 1000);
  localparam logic [7:0] SYNC_TYPE_MAX = 8'hF0;
  // ==========================================
  // answer framing
  localparam logic [2:0] SEG_LAST_POS = 3'h6;
  localparam int STR_BYTES = 16;
  localparam logic [4:0] LEN_U8 = 5'h01;
  localparam logic [4:0] LEN_U32 = 5'h04;
  localparam logic [127:0] DEV_NAME_STR =
    128'h0000_0000_0000_0000_0049_4F2D_4E4F_4445;
  localparam logic [4:0] DEV_NAME_LEN = 5'h07;
  localparam logic [127:0] HW_VERSION_STR =
    128'h0000_0000_0000_0000_4857_2D30_312E_3030;
  localparam logic [4:0] HW_VERSION_LEN = 5'h08;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b11
  } cocb_state_t;
endpackage : cocb_pkg

/* File: hw/cocb_hist_if.sv */
interface cocb_hist_if;
  logic push;
  logic [31:0] push_entry;
  logic clear;
  logic [3:0] rd_sub;
  logic [3:0] count;
  logic [31:0] rd_entry;
  modport store (input push, push_entry, clear, rd_sub,
                 output count, rd_entry);
  modport user (output push, push_entry, clear, rd_sub,
                input count, rd_entry);
endinterface : cocb_hist_if

/* File: hw/cocb_error_history.sv */
module cocb_error_history
  import cocb_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // store side
  cocb_hist_if.store hist
);
  logic [31:0] entry_reg [HIST_DEPTH];
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] count_inc;
  logic rd_ok;
  logic [3:0] rd_pos;
  // ==========================================
  // count
  assign count_inc = (count_reg == 4'(HIST_DEPTH)) ? count_reg
                     : count_reg + 4'h1;
  // an error in the clearing cycle survives the clear
  assign count_next = hist.push ? (hist.clear ? 4'h1 : count_inc)
                      : (hist.clear ? 4'h0 : count_reg);
  always_ff @(posedge clk_in)
  begin
    count_reg <= nrst_in ? count_next : 4'h0;
  end
  // ==========================================
  // entries, newest at slot 0
  genvar gi;
  generate
    for (gi = 0; gi < HIST_DEPTH; gi++)
    begin : g_slot
      always_ff @(posedge clk_in)
      begin
        if (!nrst_in || (hist.clear && (!hist.push || gi != 0)))
          entry_reg[gi] <= 32'h0000_0000;
        else if (hist.push)
          entry_reg[gi] <= (gi == 0) ? hist.push_entry
                           : entry_reg[(gi == 0) ? 0 : gi - 1];
      end
    end
  endgenerate
  // ==========================================
  // read
  assign rd_ok = (hist.rd_sub != 4'h0) && (hist.rd_sub <= count_reg);
  assign rd_pos = hist.rd_sub - 4'h1;
  assign hist.rd_entry = rd_ok ? entry_reg[rd_pos] : 32'h0000_0000;
  assign hist.count = count_reg;
endmodule : cocb_error_history

/* File: hw/cocb_sync_watchdog.sv */
module cocb_sync_watchdog
  import cocb_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // control
  input wire logic [31:0] period_in,
  input wire logic armed_in,
  input wire logic sync_in,
  // result
  output logic expired_out
);
  logic [6:0] pre_reg;
  logic [33:0] elapsed_reg;
  logic fired_reg;
  logic run;
  logic tick;
  logic hit;
  logic [33:0] limit;
  // ==========================================
  // zero period switches the check off
  assign run = armed_in && (period_in != 32'h0000_0000);
  assign tick = pre_reg == 7'(HALF_US_CYC - 1);
  assign limit = 34'(period_in) * 34'(WD_HALF_US_PER_US);
  assign hit = run && !fired_reg && (elapsed_reg >= limit);
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || !run || sync_in || tick)
      pre_reg <= 7'h00;
    else
      pre_reg <= pre_reg + 7'h01;
  end
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || !run || sync_in)
      elapsed_reg <= 34'h0_0000_0000;
    else if (tick && !fired_reg)
      elapsed_reg <= elapsed_reg + 34'h0_0000_0001;
  end
  // fires once per missing sync, not every cycle after
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || !run || sync_in)
      fired_reg <= 1'b0;
    else if (hit)
      fired_reg <= 1'b1;
  end
  always_ff @(posedge clk_in)
  begin
    expired_out <= nrst_in && hit;
  end
endmodule : cocb_sync_watchdog

/* File: hw/cocb_comm_object_bank.sv */
// Notes on behaviour
// - type word: profile low, signal info high
// - low four bits flag present I/O kinds
// - special modules never set signal bits
// - generic flag bit 0 on every error
// - bit 4 flags receive overrun
// - bit 7 vendor error; others reserved
// - newest error at entry 1, ten kept
// - writing zero to entry 0 clears history
// - history empty after reset
// - entry: code low, trigger code high
// - multi-byte values go low byte first
// - sync id default 0x80000080, never producer
// - sync id bit 31 has no effect
// - watchdog 1.5 periods; zero disables
// - immediate update only under four conditions
// - strings answered as segmented transfers
module cocb_comm_object_bank
  import cocb_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // object request
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [15:0] req_index_in,
  input wire logic [7:0] req_sub_in,
  input wire logic [31:0] req_wdata_in,
  // object answer
  output logic busy_out,
  output logic ans_valid_out,
  output logic [7:0] ans_byte_out,
  output logic ans_last_out,
  output logic ans_seg_end_out,
  output logic ans_segmented_out,
  output logic ans_done_out,
  output logic ans_abort_out,
  // fitted i/o kinds
  input wire logic has_din_in,
  input wire logic has_dout_in,
  input wire logic has_ain_in,
  input wire logic has_aout_in,
  // error events
  input wire logic err_event_in,
  input wire logic [15:0] err_code_in,
  input wire logic [15:0] err_add_in,
  input wire logic err_overrun_in,
  input wire logic err_vendor_in,
  // sync operation
  input wire logic sync_rx_in,
  input wire logic sync_pdo_mode_in,
  input wire logic pdo_all_sync_in,
  input wire logic [7:0] pdo_low_type_in,
  input wire logic fault_ack_in,
  // node status
  output logic fault_out,
  output logic io_update_out,
  output logic sync_producer_out
);
  cocb_hist_if hist ();
  cocb_state_t state_reg;
  cocb_state_t state_next;
  logic [31:0] device_type_reg;
  logic [7:0] err_flags_reg;
  logic [7:0] err_flags_next;
  logic [7:0] err_set;
  logic [31:0] sync_id_reg;
  logic [31:0] sync_period_reg;
  logic [127:0] data_reg;
  logic [4:0] len_reg;
  logic [3:0] pos_reg;
  logic [2:0] seg_reg;
  logic string_reg;
  logic abort_reg;
  logic take;
  logic at_dt;
  logic at_ef;
  logic at_sid;
  logic at_sp;
  logic at_dn;
  logic at_hw;
  logic at_hist;
  logic hist_sub0;
  logic hist_entry_ok;
  logic wr_ok;
  logic rd_ok;
  logic refuse;
  logic is_string;
  logic wr_zero;
  logic [31:0] rd_word;
  logic [4:0] rd_len;
  logic [127:0] rd_data;
  logic last_byte;
  logic [7:0] cur_byte;
  logic fast_ok;
  logic [39:0] fast_product;
  logic wd_expired;

  // ==========================================
  // decode helpers
  function automatic logic obj_at(input logic [15:0] idx,
                                  input logic [7:0] sub,
                                  input logic [15:0] want);
    obj_at = (idx == want) && (sub == 8'h00);
  endfunction : obj_at

  // string byte 0 is the first character
  function automatic logic [127:0] str_le(input logic [127:0] str,
                                          input logic [4:0] len);
    logic [127:0] res;
    res = 128'h0;
    for (int i = 0; i < STR_BYTES; i++)
    begin
      if (5'(i) < len)
        res[i*8 +: 8] = str[(32'(len) - 1 - i)*8 +: 8];
    end
    str_le = res;
  endfunction : str_le

  // ==========================================
  // request decode
  assign take = (state_reg == ST_IDLE) && req_in;
  assign at_dt = obj_at(req_index_in, req_sub_in, IDX_DEVICE_TYPE);
  assign at_ef = obj_at(req_index_in, req_sub_in, IDX_ERROR_FLAGS);
  assign at_sid = obj_at(req_index_in, req_sub_in, IDX_SYNC_ID);
  assign at_sp = obj_at(req_index_in, req_sub_in, IDX_SYNC_PERIOD);
  assign at_dn = obj_at(req_index_in, req_sub_in, IDX_DEV_NAME);
  assign at_hw = obj_at(req_index_in, req_sub_in, IDX_HW_VERSION);
  assign at_hist = req_index_in == IDX_ERROR_HISTORY;
  assign hist_sub0 = at_hist && (req_sub_in == 8'h00);
  // entries beyond the stored count do not exist
  assign hist_entry_ok = at_hist && (req_sub_in != 8'h00)
                         && (req_sub_in <= {4'h0, hist.count});
  assign hist.rd_sub = req_sub_in[3:0];
  assign wr_zero = req_wdata_in == 32'h0000_0000;
  // only the rw objects accept writes
  assign wr_ok = at_sp
                 | (at_sid & ~req_wdata_in[SYNC_PRODUCER_BIT])
                 | (hist_sub0 & wr_zero);
  assign rd_ok = at_dt | at_ef | at_sid | at_sp | at_dn | at_hw
                 | hist_sub0 | hist_entry_ok;
  assign refuse = req_write_in ? ~wr_ok : ~rd_ok;
  assign is_string = at_dn | at_hw;
  assign rd_word = at_dt ? device_type_reg
                   : at_ef ? {24'h000000, err_flags_reg}
                   : at_sid ? sync_id_reg
                   : at_sp ? sync_period_reg
                   : hist_sub0 ? {28'h0000000, hist.count}
                   : hist.rd_entry;
  assign rd_len = at_dn ? DEV_NAME_LEN
                  : at_hw ? HW_VERSION_LEN
                  : (at_ef | hist_sub0) ? LEN_U8
                  : LEN_U32;
  assign rd_data = at_dn ? str_le(DEV_NAME_STR, DEV_NAME_LEN)
                   : at_hw ? str_le(HW_VERSION_STR, HW_VERSION_LEN)
                   : {96'h0, rd_word};

  // ==========================================
  // answer sequencing
  assign last_byte = {1'b0, pos_reg} == (len_reg - 5'h01);
  assign cur_byte = data_reg[pos_reg*8 +: 8];
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take)
          state_next = (req_write_in || refuse) ? ST_DONE : ST_SEND;
      end
      ST_SEND:
      begin
        if (last_byte)
          state_next = ST_DONE;
      end
      ST_DONE:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    state_reg <= nrst_in ? state_next : ST_IDLE;
    busy_out <= nrst_in && (state_next != ST_IDLE);
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      data_reg <= 128'h0;
      len_reg <= 5'h00;
      string_reg <= 1'b0;
      abort_reg <= 1'b0;
    end
    else if (take)
    begin
      data_reg <= rd_data;
      len_reg <= rd_len;
      string_reg <= is_string;
      abort_reg <= refuse;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || state_reg != ST_SEND)
    begin
      pos_reg <= 4'h0;
      seg_reg <= 3'h0;
    end
    else
    begin
      pos_reg <= pos_reg + 4'h1;
      seg_reg <= (seg_reg == SEG_LAST_POS) ? 3'h0 : seg_reg + 3'h1;
    end
  end

  // ==========================================
  // answer outputs, all registered
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      ans_valid_out <= 1'b0;
      ans_byte_out <= 8'h00;
      ans_last_out <= 1'b0;
      ans_seg_end_out <= 1'b0;
    end
    else
    begin
      ans_valid_out <= state_reg == ST_SEND;
      ans_byte_out <= (state_reg == ST_SEND) ? cur_byte : 8'h00;
      ans_last_out <= (state_reg == ST_SEND) && last_byte;
      // seven data bytes fit one segment
      ans_seg_end_out <= (state_reg == ST_SEND) && string_reg
                         && (last_byte || seg_reg == SEG_LAST_POS);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      ans_segmented_out <= 1'b0;
      ans_done_out <= 1'b0;
      ans_abort_out <= 1'b0;
    end
    else
    begin
      ans_segmented_out <= (state_reg == ST_SEND) && string_reg;
      ans_done_out <= state_reg == ST_DONE;
      ans_abort_out <= (state_reg == ST_DONE) && abort_reg;
    end
  end

  // ==========================================
  // device type, rebuilt each cycle from fitted kinds
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      device_type_reg <= DEVICE_TYPE_RESET;
    else
      device_type_reg <= {SIG_UPPER_ZERO, has_aout_in, has_ain_in,
                          has_dout_in, has_din_in,
                          PROFILE_NUM};
  end

  // ==========================================
  // error flags and history
  always_comb
  begin
    err_set = 8'h00;
    err_set[ERR_GENERIC_BIT] = err_event_in;
    err_set[ERR_COMM_BIT] = err_event_in && err_overrun_in;
    err_set[ERR_VENDOR_BIT] = err_event_in && err_vendor_in;
  end
  // flags follow the history clear; a new error wins over it
  assign err_flags_next = (hist.clear ? 8'h00 : err_flags_reg) | err_set;
  always_ff @(posedge clk_in)
  begin
    err_flags_reg <= nrst_in ? err_flags_next : ERR_FLAGS_RESET;
  end

  assign hist.push = err_event_in;
  assign hist.push_entry = {err_add_in, err_code_in};
  assign hist.clear = take && req_write_in && hist_sub0 && wr_zero;

  cocb_error_history u_history
  (
    .clk_in (clk_in),
    .nrst_in (nrst_in),
    .hist (hist.store)
  );

  // ==========================================
  // sync objects
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      sync_id_reg <= SYNC_ID_RESET;
    else if (take && req_write_in && at_sid && wr_ok)
      sync_id_reg <= req_wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      sync_period_reg <= SYNC_PERIOD_RESET;
    else if (take && req_write_in && at_sp)
      sync_period_reg <= req_wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    sync_producer_out <= nrst_in && sync_id_reg[SYNC_PRODUCER_BIT];
  end

  // ==========================================
  // sync watchdog and fault state
  cocb_sync_watchdog u_watchdog
  (
    .clk_in (clk_in),
    .nrst_in (nrst_in),
    .period_in (sync_period_reg),
    .armed_in (sync_pdo_mode_in),
    .sync_in (sync_rx_in),
    .expired_out (wd_expired)
  );

  // a timeout in the acknowledge cycle keeps the fault
  always_ff @(posedge clk_in)
  begin
    fault_out <= nrst_in && (wd_expired
                 || (fault_out && !fault_ack_in));
  end

  // ==========================================
  // immediate i/o update on sync
  assign fast_product = 40'(sync_period_reg) * 40'(pdo_low_type_in);
  assign fast_ok = pdo_all_sync_in
                   && (pdo_low_type_in <= SYNC_TYPE_MAX)
                   && (sync_period_reg != 32'h0000_0000)
                   && (fast_product < SYNC_FAST_US);
  always_ff @(posedge clk_in)
  begin
    io_update_out <= nrst_in && sync_rx_in && fast_ok;
  end
endmodule : cocb_comm_object_bank

/* File: verif/cocb_asserts.sv */
module cocb_asserts
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // object port
  input wire logic req_in,
  input wire logic busy_out,
  input wire logic ans_valid_out,
  input wire logic [7:0] ans_byte_out,
  input wire logic ans_last_out,
  input wire logic ans_seg_end_out,
  input wire logic ans_segmented_out,
  input wire logic ans_done_out,
  input wire logic ans_abort_out,
  // sync operation
  input wire logic sync_rx_in,
  input wire logic pdo_all_sync_in,
  input wire logic fault_ack_in,
  input wire logic fault_out,
  input wire logic io_update_out,
  input wire logic sync_producer_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // sequences
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_take;
    req_in && !busy_out;
  endsequence
  sequence s_close;
    ans_valid_out && ans_last_out ##1 ans_done_out && !busy_out;
  endsequence
  // ==========================================
  // checks
  a_take_busy: assert property (s_take |=> busy_out)
    else $error("request taken but busy did not rise");
  a_answer_bound: assert property (s_take |-> ##[2:18] ans_done_out)
    else $error("answer did not end within 18 cycles");
  a_last_then_done: assert property (ans_last_out |-> s_close)
    else $error("last byte not followed by done");
  a_idle_byte: assert property (!ans_valid_out |-> ans_byte_out == 8'h00)
    else $error("answer byte nonzero while not valid");
  a_seg_end: assert property
    (ans_seg_end_out |-> ans_valid_out && ans_segmented_out)
    else $error("segment end outside a string byte");
  a_abort_done: assert property (ans_abort_out |-> ans_done_out)
    else $error("abort without done");
  a_never_producer: assert property (sync_producer_out == 1'b0)
    else $error("node claims to produce sync");
  a_update_cause: assert property
    (io_update_out |-> $past(sync_rx_in) && $past(pdo_all_sync_in))
    else $error("io update without sync or without all sync pdos");
  a_fault_sticky: assert property
    (fault_out && !fault_ack_in |=> fault_out)
    else $error("fault dropped without acknowledge");
endmodule : cocb_asserts

bind cocb_comm_object_bank cocb_asserts u_chk (.*);

/* File: verif/cocb_can_master.sv */
module cocb_can_master
(
  // clock
  input wire logic clk_in,
  // request
  output logic req_out,
  output logic wr_out,
  output logic [15:0] idx_out,
  output logic [7:0] sub_out,
  output logic [31:0] wdata_out,
  // answer
  input wire logic busy_in,
  input wire logic valid_in,
  input wire logic [7:0] byte_in,
  input wire logic seg_end_in,
  input wire logic segmented_in,
  input wire logic done_in,
  input wire logic abort_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [127:0] rd_buf;
  logic [15:0] seg_mask;
  int n_bytes;
  logic aborted;
  logic all_seg;
  logic tmo;
  initial
  begin
    req_out = 1'b0;
    wr_out = 1'b0;
    idx_out = 16'h0000;
    sub_out = 8'h00;
    wdata_out = 32'h0000_0000;
  end
  // ==========================================
  // one transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd);
    int i;
    rd_buf = '0;
    seg_mask = '0;
    n_bytes = 0;
    all_seg = 1'b1;
    req_out = 1'b1;
    wr_out = wr;
    idx_out = idx;
    sub_out = sub;
    wdata_out = wd;
    i = 0;
    while (busy_in && i < 40)
    begin
      @(posedge clk_in);
      #1;
      i++;
    end
    @(posedge clk_in);
    #1;
    // index and write data park on the inverse; wr and sub keep the last value
    req_out = 1'b0;
    idx_out = ~idx;
    wdata_out = ~wd;
    while (!done_in && i < 80)
    begin
      if (valid_in && n_bytes < 16)
      begin
        rd_buf[8*n_bytes +: 8] = byte_in;
        seg_mask[n_bytes] = seg_end_in;
        all_seg = all_seg & segmented_in;
        n_bytes++;
      end
      @(posedge clk_in);
      #1;
      i++;
    end
    aborted = abort_in;
    tmo = (i >= 80);
  endtask : xfer
endmodule : cocb_can_master

/* File: verif/cocb_comm_object_bank_tb_top.sv */
module cocb_comm_object_bank_tb_top
  import cocb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic req_in, req_write_in;
  logic [15:0] req_index_in;
  logic [7:0] req_sub_in;
  logic [31:0] req_wdata_in;
  logic busy_out, ans_valid_out, ans_last_out, ans_seg_end_out;
  logic ans_segmented_out, ans_done_out, ans_abort_out;
  logic [7:0] ans_byte_out;
  logic has_din_in = 1'b0, has_dout_in = 1'b0;
  logic has_ain_in = 1'b0, has_aout_in = 1'b0;
  logic err_event_in = 1'b0, err_overrun_in = 1'b0;
  logic err_vendor_in = 1'b0;
  logic [15:0] err_code_in = 16'h0000, err_add_in = 16'h0000;
  logic sync_rx_in = 1'b0, sync_pdo_mode_in = 1'b0;
  logic pdo_all_sync_in = 1'b0, fault_ack_in = 1'b0;
  logic [7:0] pdo_low_type_in = 8'h00;
  logic fault_out, io_update_out, sync_producer_out;
  int n_errors = 0;
  int checked = 0;
  always #2.5 clk_in = ~clk_in;
  cocb_comm_object_bank dut (.*);
  cocb_can_master m (.clk_in(clk_in), .req_out(req_in),
    .wr_out(req_write_in), .idx_out(req_index_in), .sub_out(req_sub_in),
    .wdata_out(req_wdata_in), .busy_in(busy_out),
    .valid_in(ans_valid_out), .byte_in(ans_byte_out),
    .seg_end_in(ans_seg_end_out), .segmented_in(ans_segmented_out),
    .done_in(ans_done_out), .abort_in(ans_abort_out));
  // ==========================================
  // shared tasks
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic go(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd);
    m.xfer(wr, idx, sub, wd);
    if (m.tmo)
    begin
      n_errors++;
      print_verdict();
    end
  endtask : go
  task automatic rdchk(input string what, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] exp, input int len);
    go(1'b0, idx, sub, 32'h0000_0000);
    chk(what, exp, m.rd_buf[31:0]);
    chk(what, 32'(len), 32'(m.n_bytes));
    chk(what, 32'h0000_0000, 32'(m.aborted));
    chk(what, 32'h0000_0000, 32'(m.all_seg));
  endtask : rdchk
  task automatic refuse(input string what, input logic wr,
    input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    go(wr, idx, sub, wd);
    chk(what, 32'h0000_0001, 32'(m.aborted));
  endtask : refuse
  task automatic err(input logic [15:0] code, input logic [1:0] q);
    err_event_in = 1'b1;
    err_code_in = code;
    err_add_in = ~code;
    {err_vendor_in, err_overrun_in} = q;
    @(posedge clk_in);
    #1;
    err_event_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : err
  task automatic sync_pulse(output logic io);
    sync_rx_in = 1'b1;
    @(posedge clk_in);
    #1;
    sync_rx_in = 1'b0;
    io = io_update_out;
    @(posedge clk_in);
    #1;
  endtask : sync_pulse
  // ==========================================
  // scenarios
  task automatic t_reset();
    rdchk("sync id", IDX_SYNC_ID, 8'h00, 32'h8000_0080, 4);
    rdchk("period", IDX_SYNC_PERIOD, 8'h00, 32'h0000_0000, 4);
    rdchk("count", IDX_ERROR_HISTORY, 8'h00, 32'h0000_0000, 1);
    rdchk("flags", IDX_ERROR_FLAGS, 8'h00, 32'h0000_0000, 1);
    refuse("entry", 1'b0, IDX_ERROR_HISTORY, 8'h01, 32'h0);
  endtask : t_reset
  task automatic t_dev_type();
    for (int k = 0; k < 16; k++)
    begin
      {has_aout_in, has_ain_in, has_dout_in, has_din_in} = 4'(k);
      // the type word is registered: let it take the new kinds first
      @(posedge clk_in);
      #1;
      rdchk("type", IDX_DEVICE_TYPE, 8'h00,
        {12'h000, 4'(k), 16'h0191}, 4);
    end
  endtask : t_dev_type
  task automatic t_errors();
    err(16'h1000, 2'b00);
    rdchk("flags", IDX_ERROR_FLAGS, 8'h00, 32'h0000_0001, 1);
    err(16'h1001, 2'b01);
    rdchk("flags", IDX_ERROR_FLAGS, 8'h00, 32'h0000_0011, 1);
    err(16'h1002, 2'b10);
    rdchk("flags", IDX_ERROR_FLAGS, 8'h00, 32'h0000_0091, 1);
    for (int k = 3; k < 11; k++)
      err(16'h1000 + 16'(k), 2'b00);
    rdchk("count", IDX_ERROR_HISTORY, 8'h00, 32'h0000_000A, 1);
    rdchk("newest", IDX_ERROR_HISTORY, 8'h01,
      {~16'h100A, 16'h100A}, 4);
    rdchk("oldest", IDX_ERROR_HISTORY, 8'h0A,
      {~16'h1001, 16'h1001}, 4);
    refuse("sub 11", 1'b0, IDX_ERROR_HISTORY, 8'h0B, 32'h0);
  endtask : t_errors
  task automatic t_clear();
    refuse("clr 5", 1'b1, IDX_ERROR_HISTORY, 8'h00, 32'h5);
    rdchk("count", IDX_ERROR_HISTORY, 8'h00, 32'h0000_000A, 1);
    refuse("entry wr", 1'b1, IDX_ERROR_HISTORY, 8'h01, 32'h0);
    go(1'b1, IDX_ERROR_HISTORY, 8'h00, 32'h0000_0000);
    chk("clear", 32'h0000_0000, 32'(m.aborted));
    rdchk("count", IDX_ERROR_HISTORY, 8'h00, 32'h0000_0000, 1);
    rdchk("flags", IDX_ERROR_FLAGS, 8'h00, 32'h0000_0000, 1);
  endtask : t_clear
  task automatic t_writes();
    refuse("type wr", 1'b1, IDX_DEVICE_TYPE, 8'h00, 32'h1);
    refuse("flags wr", 1'b1, IDX_ERROR_FLAGS, 8'h00, 32'h1);
    refuse("name wr", 1'b1, IDX_DEV_NAME, 8'h00, 32'h1);
    refuse("hw wr", 1'b1, IDX_HW_VERSION, 8'h00, 32'h1);
    refuse("unknown", 1'b0, 16'h1002, 8'h00, 32'h0);
    refuse("sub", 1'b0, IDX_SYNC_ID, 8'h01, 32'h0);
    refuse("producer", 1'b1, IDX_SYNC_ID, 8'h00, 32'h4000_0080);
    go(1'b1, IDX_SYNC_ID, 8'h00, 32'h0000_0181);
    rdchk("sync id", IDX_SYNC_ID, 8'h00, 32'h0000_0181, 4);
    go(1'b1, IDX_SYNC_ID, 8'h00, 32'h8000_07FF);
    rdchk("bit 31", IDX_SYNC_ID, 8'h00, 32'h8000_07FF, 4);
  endtask : t_writes
  task automatic t_str(input logic [15:0] idx, input string s);
    go(1'b0, idx, 8'h00, 32'h0000_0000);
    chk("length", 32'(s.len()), 32'(m.n_bytes));
    chk("segmented", 32'h0000_0001, 32'(m.all_seg));
    for (int k = 0; k < s.len(); k++)
    begin
      chk("char", 32'(s[k]), 32'(m.rd_buf[8*k +: 8]));
      chk("seg end", 32'(k % 7 == 6 || k == s.len() - 1),
        32'(m.seg_mask[k]));
    end
  endtask : t_str
  task automatic t_watchdog();
    int i;
    logic io;
    // 1 us period gives a 300 cycle watchdog
    go(1'b1, IDX_SYNC_PERIOD, 8'h00, 32'h0000_0001);
    sync_pdo_mode_in = 1'b1;
    sync_pulse(io);
    // fault may only rise once 1.5 periods have passed
    repeat (298) @(posedge clk_in);
    #1;
    chk("early", 32'h0000_0000, 32'(fault_out));
    i = 0;
    while (fault_out !== 1'b1 && i < 8)
    begin
      @(posedge clk_in);
      #1;
      i++;
    end
    chk("fault", 32'h0000_0001, 32'(fault_out));
    if (fault_out !== 1'b1)
      print_verdict();
    fault_ack_in = 1'b1;
    @(posedge clk_in);
    #1;
    fault_ack_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("ack", 32'h0000_0000, 32'(fault_out));
    // syncs inside the interval keep the fault away
    sync_pulse(io);
    repeat (200) @(posedge clk_in);
    sync_pulse(io);
    repeat (200) @(posedge clk_in);
    #1;
    chk("held off", 32'h0000_0000, 32'(fault_out));
    go(1'b1, IDX_SYNC_PERIOD, 8'h00, 32'h0000_0000);
    sync_pulse(io);
    repeat (600) @(posedge clk_in);
    #1;
    chk("zero off", 32'h0000_0000, 32'(fault_out));
    sync_pdo_mode_in = 1'b0;
  endtask : t_watchdog
  task automatic t_io();
    logic io;
    logic [31:0] per [6] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h177, 32'h176};
    logic [7:0] typ [6] = '{8'h01, 8'hF1, 8'h01, 8'h01, 8'hF0, 8'hF0};
    logic [5:0] all = 6'b110111;
    logic [5:0] exp = 6'b100001;
    // 0x177 * 240 is exactly 90 ms, not below it
    for (int k = 0; k < 6; k++)
    begin
      go(1'b1, IDX_SYNC_PERIOD, 8'h00, per[k]);
      pdo_low_type_in = typ[k];
      pdo_all_sync_in = all[5-k];
      sync_pulse(io);
      chk("io update", 32'(exp[5-k]), 32'(io));
    end
  endtask : t_io
  // ==========================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_reset();
    t_dev_type();
    t_errors();
    t_clear();
    t_writes();
    t_str(IDX_DEV_NAME, "IO-NODE");
    t_str(IDX_HW_VERSION, "HW-01.00");
    t_watchdog();
    t_io();
    print_verdict();
  end
endmodule : cocb_comm_object_bank_tb_top
